// ===== hdl/trig_sel_pkg.sv
// constants shared by the trigger selection block
// Functional notes
// R1: free-run mode starts recording after setup only
// R2: force command triggers only while armed
// R3: direction zero keeps connector driver off
// R4: internal mode output drives high at start
// R5: external mode forces connector to input
// R6: external mode codes alone enable input
// R7: external trigger is never echoed out
// R8: rising edge mode triggers on low-high
// R9: falling edge mode triggers on high-low
// R10: dual edge mode triggers on either edge
// R11: long high pulse beyond width triggers
// R12: short high pulse below width triggers
// R13: long low pulse beyond width triggers
// R14: short low pulse below width triggers
// R15: termination one low, zero high impedance
// R16: pulse width samples, only 2..255 accepted
// R17: one trigger per run, re-arm after finish
// R18: short pulse never fires long mode
// R19: input synchronised, lengths in sample clocks
// R20: reset: free-run, driver off, nothing pending
package trig_sel_pkg;
    // printed offsets are register indexes; byte address is index * 4
    localparam logic [17:0] IDX_COMMAND = 18'h00000;
    localparam logic [17:0] IDX_MODE = 18'h09c40;
    localparam logic [17:0] IDX_DIRECTION = 18'h09ca4;
    localparam logic [17:0] IDX_TERMINATION = 18'h09cae;
    localparam logic [17:0] IDX_PULSE_WIDTH = 18'h0abe0;
    localparam logic [17:0] IDX_STATUS = 18'h0ac44;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 19;

    // trigger mode codes
    localparam logic [31:0] MODE_FREE_RUN = 32'h00000000;
    localparam logic [31:0] MODE_RISE = 32'h00004e20;
    localparam logic [31:0] MODE_FALL = 32'h00004e2a;
    localparam logic [31:0] MODE_BOTH = 32'h00004e3e;
    localparam logic [31:0] MODE_HIGH_LONG = 32'h00004e21;
    localparam logic [31:0] MODE_HIGH_SHORT = 32'h00004e22;
    localparam logic [31:0] MODE_LOW_LONG = 32'h00004e2b;
    localparam logic [31:0] MODE_LOW_SHORT = 32'h00004e2c;

    // board commands
    localparam logic [31:0] CMD_FORCE = 32'h00000010;
    localparam logic [31:0] CMD_START = 32'h00000004;
    localparam logic [31:0] CMD_STOP = 32'h00000040;

    // pulse width limits and reset value
    localparam logic [7:0] PW_MIN = 8'h02;
    localparam logic [7:0] PW_RESET = 8'h02;

    // status register fields
    localparam int ST_IDLE_BIT = 0;
    localparam int ST_SETUP_BIT = 1;
    localparam int ST_ARMED_BIT = 2;
    localparam int ST_RUN_BIT = 3;
    localparam int ST_EXT_BIT = 4;
    localparam int ST_OE_BIT = 5;
    localparam int ST_LEVEL_BIT = 6;
    localparam int ST_COUNT_LSB = 16;

    // setup delay before arming
    localparam real SETUP_TIME_NS = 64.0;
    localparam real CLK_PERIOD_NS = 8.0;
    localparam int SETUP_CYCLES_I = int'(SETUP_TIME_NS / CLK_PERIOD_NS);
    localparam logic [7:0] SETUP_CYCLES = 8'(SETUP_CYCLES_I);

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_SETUP = 4'h2,
        S_ARMED = 4'h4,
        S_RUN = 4'h8
    } run_state_e;
endpackage : trig_sel_pkg

// ===== hdl/level_sync.sv
// two-stage synchroniser for the trigger connector input
`timescale 1ns/1ps
module level_sync
(
    input wire logic mclk,   // sample clock
    input wire logic resetn, // async reset, active low
    input wire logic din,    // asynchronous level
    output logic dout        // synchronised level
);
    logic meta_q;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : level_sync

// ===== hdl/pulse_meter.sv
// measures one polarity of pulses in sample clocks
`timescale 1ns/1ps
module pulse_meter
(
    input wire logic mclk,        // sample clock
    input wire logic resetn,      // async reset, active low
    input wire logic lvl,         // synchronised input level
    input wire logic pol,         // level that forms the pulse
    input wire logic [7:0] width, // threshold in samples
    output logic long_hit,        // pulse got longer than width
    output logic short_hit        // pulse ended shorter than width
);
    logic prev_q;
    logic in_pulse_q;
    logic [8:0] cnt_q;

    // a pulse is only measured after its leading edge was seen
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            prev_q <= 1'b0;
            in_pulse_q <= 1'b0;
            cnt_q <= 9'h000;
            long_hit <= 1'b0;
            short_hit <= 1'b0;
        end
        else
        begin
            prev_q <= lvl;
            long_hit <= 1'b0;
            short_hit <= 1'b0;
            if (lvl == pol && prev_q != pol)
            begin
                in_pulse_q <= 1'b1;
                cnt_q <= 9'h001;
            end
            else if (lvl == pol && in_pulse_q)
            begin
                if (cnt_q != 9'h1ff)
                    cnt_q <= cnt_q + 9'h001;
                // fires on sample width+1, never earlier [R11] [R13] [R18]
                if (cnt_q == {1'b0, width})
                    long_hit <= 1'b1;
            end
            else if (lvl != pol && in_pulse_q)
            begin
                in_pulse_q <= 1'b0;
                // judged when the trailing edge arrives [R12] [R14]
                if (cnt_q < {1'b0, width})
                    short_hit <= 1'b1;
            end
        end
    end
endmodule : pulse_meter

// ===== hdl/acquisition_trigger_select.sv
// trigger source selection, detection and connector control
`timescale 1ns/1ps
module acquisition_trigger_select
    import trig_sel_pkg::*;
(
    input wire logic mclk,          // 125 MHz sample clock
    input wire logic resetn,        // async reset, active low
    input wire logic hsel,          // ahb slave select
    input wire logic [31:0] haddr,  // ahb address
    input wire logic [1:0] htrans,  // ahb transfer type
    input wire logic hwrite,        // ahb write
    input wire logic [2:0] hsize,   // ahb size
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready,        // ahb bus ready
    output logic [31:0] hrdata,     // ahb read data
    output logic hreadyout,         // ahb slave ready
    output logic hresp,             // ahb response
    input wire logic acq_done,      // recording or replay finished
    input wire logic trig_pin_i,    // connector level in
    output logic trig_pin_o,        // connector level out
    output logic trig_pin_oe,       // connector driver enable
    output logic term_low_z,        // low impedance termination on
    output logic trig_event,        // one-cycle trigger pulse
    output logic acq_active         // recording or replay running
);
    logic [31:0] mode_q;
    logic [31:0] dir_q;
    logic term_q;
    logic [7:0] pw_q;
    logic [15:0] trig_cnt_q;
    logic [7:0] setup_cnt_q;
    run_state_e state_q;

    logic wr_pend_q;
    logic [17:0] wr_idx_q;
    logic addr_ok;
    logic [17:0] a_idx;
    logic wr_cmd;
    logic [31:0] rd_d;

    logic lvl_s;
    logic lvl_q;
    logic hi_long;
    logic hi_short;
    logic lo_long;
    logic lo_short;
    logic ext_mode;
    logic ext_hit;
    logic force_hit;
    logic fire;
    logic start_cmd;
    logic stop_cmd;
    logic run_hold;
    logic drive_ok;
    logic mode_ok;
    logic pw_ok;

    assign a_idx = haddr[IDX_MSB:IDX_LSB];
    assign addr_ok = hsel && hready && htrans[1];

    // only the seven external codes turn the input on [R6]
    always_comb
    begin
        unique case (mode_q)
            MODE_RISE, MODE_FALL, MODE_BOTH,
            MODE_HIGH_LONG, MODE_HIGH_SHORT,
            MODE_LOW_LONG, MODE_LOW_SHORT: ext_mode = 1'b1;
            default: ext_mode = 1'b0;
        endcase
    end

    // unknown mode codes are refused so a legal mode always stays set
    always_comb
    begin
        unique case (hwdata)
            MODE_FREE_RUN, MODE_RISE, MODE_FALL, MODE_BOTH,
            MODE_HIGH_LONG, MODE_HIGH_SHORT,
            MODE_LOW_LONG, MODE_LOW_SHORT: mode_ok = 1'b1;
            default: mode_ok = 1'b0;
        endcase
    end

    // ahb: zero wait states, response always okay
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 18'h00000;
        end
        else
        begin
            wr_pend_q <= addr_ok && hwrite;
            wr_idx_q <= a_idx;
        end
    end

    // read data is captured at the address phase edge
    always_comb
    begin
        rd_d = 32'h00000000;
        unique case (a_idx)
            IDX_MODE: rd_d = mode_q;
            IDX_DIRECTION: rd_d = dir_q;
            IDX_TERMINATION: rd_d = {31'h00000000, term_q};
            IDX_PULSE_WIDTH: rd_d = {24'h000000, pw_q};
            IDX_STATUS:
            begin
                rd_d[ST_IDLE_BIT] = state_q == S_IDLE;
                rd_d[ST_SETUP_BIT] = state_q == S_SETUP;
                rd_d[ST_ARMED_BIT] = state_q == S_ARMED;
                rd_d[ST_RUN_BIT] = state_q == S_RUN;
                rd_d[ST_EXT_BIT] = ext_mode;
                rd_d[ST_OE_BIT] = trig_pin_oe;
                rd_d[ST_LEVEL_BIT] = lvl_s;
                rd_d[ST_COUNT_LSB +: 16] = trig_cnt_q;
            end
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            hrdata <= 32'h00000000;
        else if (addr_ok && !hwrite)
            hrdata <= rd_d;
    end

    // configuration registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= MODE_FREE_RUN; // [R20]
            dir_q <= 32'h00000000;
            term_q <= 1'b0;
            pw_q <= PW_RESET;
        end
        else if (wr_pend_q)
        begin
            unique case (wr_idx_q)
                IDX_MODE:
                begin
                    if (mode_ok)
                        mode_q <= hwdata;
                end
                IDX_DIRECTION: dir_q <= hwdata;
                IDX_TERMINATION: term_q <= hwdata[0];
                IDX_PULSE_WIDTH:
                begin
                    if (pw_ok)
                        pw_q <= hwdata[7:0]; // [R16]
                end
                default: ;
            endcase
        end
    end

    assign wr_cmd = wr_pend_q && wr_idx_q == IDX_COMMAND;
    // widths outside the legal range are refused and the old one stays
    assign pw_ok = hwdata[31:8] == 24'h000000 && hwdata[7:0] >= PW_MIN;

    // external input path
    level_sync u_sync
    (
        .mclk(mclk),
        .resetn(resetn),
        .din(trig_pin_i),
        .dout(lvl_s)
    ); // [R19]

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            lvl_q <= 1'b0;
        else
            lvl_q <= lvl_s;
    end

    pulse_meter u_high
    (
        .mclk(mclk),
        .resetn(resetn),
        .lvl(lvl_s),
        .pol(1'b1),
        .width(pw_q),
        .long_hit(hi_long),
        .short_hit(hi_short)
    );

    pulse_meter u_low
    (
        .mclk(mclk),
        .resetn(resetn),
        .lvl(lvl_s),
        .pol(1'b0),
        .width(pw_q),
        .long_hit(lo_long),
        .short_hit(lo_short)
    );

    // edges compare this sample with the previous synchronised one
    always_comb
    begin
        unique case (mode_q)
            MODE_RISE: ext_hit = lvl_s && !lvl_q; // [R8]
            MODE_FALL: ext_hit = !lvl_s && lvl_q; // [R9]
            MODE_BOTH: ext_hit = lvl_s != lvl_q; // [R10]
            MODE_HIGH_LONG: ext_hit = hi_long; // [R11]
            MODE_HIGH_SHORT: ext_hit = hi_short; // [R12]
            MODE_LOW_LONG: ext_hit = lo_long; // [R13]
            MODE_LOW_SHORT: ext_hit = lo_short; // [R14]
            default: ext_hit = 1'b0;
        endcase
    end

    assign start_cmd = wr_cmd && hwdata == CMD_START;
    assign stop_cmd = wr_cmd && hwdata == CMD_STOP;
    assign force_hit = wr_cmd && hwdata == CMD_FORCE; // [R2]
    // only the armed state accepts an event; later ones are dropped
    assign fire = state_q == S_ARMED && !stop_cmd && // [R17]
                  (mode_q == MODE_FREE_RUN || ext_hit || force_hit); // [R1]

    // run control
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            state_q <= S_IDLE;
        // stop wins over every state, a run in progress included
        else if (stop_cmd)
            state_q <= S_IDLE;
        else
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    if (start_cmd)
                        state_q <= S_SETUP;
                end
                S_SETUP:
                begin
                    // the only delay before free-run recording [R1]
                    if (setup_cnt_q <= 8'h01)
                        state_q <= S_ARMED;
                end
                S_ARMED:
                begin
                    if (fire)
                        state_q <= S_RUN;
                end
                S_RUN:
                begin
                    if (acq_done)
                        state_q <= S_ARMED; // [R17]
                end
            endcase
        end
    end

    // setup countdown, loaded by start and run down while setting up
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            setup_cnt_q <= 8'h00;
        else if (state_q == S_IDLE && start_cmd)
            setup_cnt_q <= SETUP_CYCLES;
        else if (state_q == S_SETUP && setup_cnt_q > 8'h01)
            setup_cnt_q <= setup_cnt_q - 8'h01;
    end

    // a run ends on the edge that sees done or stop, so a free-run
    // retrigger right after re-arm still gives a fresh rising edge
    assign run_hold = state_q == S_RUN && !acq_done && !stop_cmd;
    // any nonzero direction asks for output, external modes win
    assign drive_ok = dir_q != 32'h00000000 && !ext_mode;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            trig_event <= 1'b0; // [R20]
        else
            trig_event <= fire;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            acq_active <= 1'b0;
        else
            acq_active <= run_hold || fire; // [R17]
    end

    // status trigger count, wraps silently after 65535 runs
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            trig_cnt_q <= 16'h0000;
        else if (fire)
            trig_cnt_q <= trig_cnt_q + 16'h0001;
    end

    // connector drives only for internal modes with direction set
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            trig_pin_oe <= 1'b0; // [R20]
        else
            trig_pin_oe <= drive_ok; // [R3] [R5]
    end

    // high for the whole run while driving, rising as it starts; input never echoed
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            trig_pin_o <= 1'b0;
        else
            trig_pin_o <= drive_ok && (run_hold || fire); // [R4] [R7]
    end

    // termination only matters while the connector is an input
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            term_low_z <= 1'b0;
        else
            term_low_z <= ext_mode && term_q; // [R15]
    end
endmodule : acquisition_trigger_select

// ===== test/trig_checker.sv
// concurrent checks on the trigger selection block's ports
`timescale 1ns/1ps
module trig_checker
(
    input wire logic mclk,        // sample clock
    input wire logic resetn,      // async reset, active low
    input wire logic hreadyout,   // ahb slave ready
    input wire logic hresp,       // ahb response
    input wire logic acq_done,    // run finished
    input wire logic trig_pin_o,  // connector level out
    input wire logic trig_pin_oe, // connector driver enable
    input wire logic term_low_z,  // low impedance termination
    input wire logic trig_event,  // trigger pulse
    input wire logic acq_active   // run in progress
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave answered with an error response");
    a_ready_on: assert property ($past(resetn) |-> hreadyout)
        else $error("slave inserted a wait state");
    a_event_pulse: assert property (trig_event |=> !trig_event)
        else $error("trigger pulse longer than one cycle");
    a_event_starts: assert property (trig_event |-> acq_active)
        else $error("trigger did not start the run");
    a_active_cause: assert property ($rose(acq_active) |-> trig_event)
        else $error("run started without a trigger");
    a_single_run: assert property (
        acq_active && $past(acq_active) |-> !trig_event)
        else $error("second trigger accepted inside a run");
    a_done_rearm: assert property (
        acq_done && acq_active && !trig_event |=> !acq_active)
        else $error("run kept going after it finished");
    a_no_echo: assert property (!trig_pin_oe |-> !trig_pin_o)
        else $error("connector level driven while driver off");
    a_out_marks: assert property (
        trig_pin_oe && acq_active |-> trig_pin_o)
        else $error("trigger output low during an internal run");
    a_out_rise: assert property ($rose(trig_pin_o) |-> trig_event)
        else $error("trigger output rose without a trigger");
    a_term_input: assert property (trig_pin_oe |-> !term_low_z)
        else $error("termination applied while connector drives");
endmodule : trig_checker

bind acquisition_trigger_select trig_checker u_chk (.mclk(mclk),
    .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp),
    .acq_done(acq_done), .trig_pin_o(trig_pin_o),
    .trig_pin_oe(trig_pin_oe), .term_low_z(term_low_z),
    .trig_event(trig_event), .acq_active(acq_active));

// ===== test/ttl_source.sv
// external ttl trigger source offering a level to the connector
`timescale 1ns/1ps
module ttl_source
(
    input wire logic mclk, // sample clock of the board
    output logic lvl       // level offered to the connector
);
    initial lvl = 1'b0;

    // moves right after an edge so lengths are whole sample clocks
    task automatic pulse(input logic p, input int n);
        if (n > 0)
        begin
            @(posedge mclk);
            lvl <= p;
            repeat (n) @(posedge mclk);
            lvl <= ~p;
        end
    endtask : pulse

    // long settle so no stale edge reaches the next mode
    task automatic idle(input logic l);
        @(posedge mclk);
        lvl <= l;
        repeat (20) @(posedge mclk);
    endtask : idle
endmodule : ttl_source

// ===== test/testbench.sv
// self-checking bench for the trigger selection block
`timescale 1ns/1ps
module testbench
    import trig_sel_pkg::*;
;
    logic mclk, resetn, hsel, hwrite, acq_done;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, trig_pin_o, trig_pin_oe, term_low_z;
    logic trig_event, acq_active, src_lvl;
    wire logic hready, trig_pin;
    int fail_count, checks_done;
    logic [2:0] q[$];
    logic [31:0] md [7] = '{MODE_RISE, MODE_FALL, MODE_BOTH,
        MODE_HIGH_LONG, MODE_HIGH_SHORT, MODE_LOW_LONG, MODE_LOW_SHORT};
    localparam logic [6:0] PL = 7'b0011110;
    localparam logic [6:0] EL = 7'b1001101;

    assign hready = hreadyout;
    // shared connector: the board wins while its driver is on
    assign trig_pin = trig_pin_oe ? trig_pin_o : src_lvl;

    acquisition_trigger_select u_dut (.mclk(mclk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .acq_done(acq_done), .trig_pin_i(trig_pin),
        .trig_pin_o(trig_pin_o), .trig_pin_oe(trig_pin_oe),
        .term_low_z(term_low_z), .trig_event(trig_event),
        .acq_active(acq_active));
    ttl_source u_src (.mclk(mclk), .lvl(src_lvl));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            chk("hready wait", 1, 0);
            wrap_up();
        end
    endtask : wait_ready

    task automatic ahb(input logic w, input logic [17:0] x,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hsize <= 3'b010;
        hwrite <= w;
        haddr <= {12'h000, x, 2'b00};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask : ahb

    task automatic wr(input logic [17:0] x, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, x, d, r);
    endtask : wr

    task automatic rdc(input logic [17:0] x, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, x, 32'h00000000, r);
        chk($sformatf("reg %h", x), e, r);
    endtask : rdc

    task automatic done_pulse();
        @(posedge mclk);
        acq_done <= 1'b1;
        @(posedge mclk);
        acq_done <= 1'b0;
    endtask : done_pulse

    task automatic drain(input int lim);
        int n;
        n = 0;
        while (q.size() != 0 && n < lim)
        begin
            @(posedge mclk);
            n++;
        end
        if (q.size() != 0)
        begin
            chk("missing event", 0, 32'(q.size()));
            q.delete();
        end
    endtask : drain

    // each trigger is paired with the oldest note of driver, level, pin
    always @(posedge mclk)
        if (resetn === 1'b1 && trig_event === 1'b1)
        begin
            if (q.size() == 0)
                chk("unexpected event", 0, 1);
            else
                chk("event pins", 32'(q.pop_front()),
                    {29'h0, trig_pin_oe, trig_pin_o, trig_pin});
        end

    initial
    begin
        int i, w, n2;
        int unsigned wv[4] = '{1, 255, 256, 2};
        int unsigned we[4] = '{2, 255, 255, 2};
        resetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        acq_done = 1'b0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'b00;
        hsize = 3'b000;
        void'($urandom(32'hd8dba96b));
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk("oe", 0, {31'h0, trig_pin_oe});
        rdc(IDX_MODE, MODE_FREE_RUN);
        rdc(IDX_DIRECTION, 0);
        rdc(IDX_PULSE_WIDTH, {24'h0, PW_RESET});
        rdc(IDX_STATUS, 32'h00000001);
        rdc(IDX_COMMAND, 0);
        rdc(18'h00001, 0);
        for (i = 0; i < 4; i++)
        begin
            wr(IDX_PULSE_WIDTH, wv[i]);
            rdc(IDX_PULSE_WIDTH, we[i]);
        end
        wr(IDX_MODE, 32'h00001234);
        rdc(IDX_MODE, MODE_FREE_RUN);
        wr(IDX_DIRECTION, 1);
        q.push_back(3'b111);
        wr(IDX_COMMAND, CMD_START);
        drain(20);
        wr(IDX_COMMAND, CMD_FORCE);
        repeat (10) @(posedge mclk);
        q.push_back(3'b111);
        done_pulse();
        drain(20);
        wr(IDX_COMMAND, CMD_STOP);
        wr(IDX_DIRECTION, 0);
        q.push_back(3'b000);
        wr(IDX_COMMAND, CMD_START);
        drain(20);
        wr(IDX_COMMAND, CMD_STOP);
        w = 4 + int'($urandom % 5);
        wr(IDX_PULSE_WIDTH, w);
        wr(IDX_DIRECTION, 1);
        for (i = 0; i < 7; i++)
        begin
            n2 = (i < 3) ? 12 : (i == 3 || i == 5) ? w + 12 : w - 2;
            u_src.idle(~PL[i]);
            wr(IDX_MODE, md[i]);
            wr(IDX_TERMINATION, i % 2);
            rdc(IDX_MODE, md[i]);
            chk("oe ext", 0, {31'h0, trig_pin_oe});
            chk("termination", i % 2, {31'h0, term_low_z});
            wr(IDX_COMMAND, CMD_START);
            repeat (12) @(posedge mclk);
            u_src.pulse(PL[i], (i < 3) ? 0 : w);
            repeat (20 + $urandom % 8) @(posedge mclk);
            q.push_back({2'b00, EL[i]});
            u_src.pulse(PL[i], n2);
            drain(60);
            // a trailing edge must pass while the run still holds
            repeat (8) @(posedge mclk);
            done_pulse();
            wr(IDX_COMMAND, CMD_STOP);
        end
        u_src.idle(1'b1);
        wr(IDX_MODE, MODE_RISE);
        wr(IDX_COMMAND, CMD_START);
        repeat (12) @(posedge mclk);
        q.push_back(3'b001);
        wr(IDX_COMMAND, CMD_FORCE);
        drain(10);
        wr(IDX_COMMAND, CMD_FORCE);
        repeat (10) @(posedge mclk);
        done_pulse();
        wr(IDX_COMMAND, CMD_STOP);
        wr(IDX_COMMAND, CMD_FORCE);
        repeat (20) @(posedge mclk);
        wrap_up();
    end

    initial
    begin
        #500000;
        fail_count++;
        wrap_up();
    end
endmodule : testbench
